// ---- ir_receive_capture_burst_count.sv ----
// IR receive timer with capture, reload, overflow and burst count.
// Assumes a classic Wishbone master and a synchronous IR input.
//
// Our own choices: the Wishbone slave port and the placing of the registers.
`timescale 1ns/10ps
`include "ir_rx_params.svh"
module ir_receive_capture_burst_count
    import ir_rx_pkg::*;
#(
    parameter int TIMER_W = 16
)
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // IR input pin
    input  wire logic        ir_in_i,
    // Interrupt and state
    output logic             irq_o,
    output logic             rx_active_o
);

    ir_event_if ev ();

    // Control register fields
    logic               enable_reg;
    logic               tx_mode_reg;
    logic               reload_on_event_reg;
    logic               burst_count_mode_reg;
    logic               count_source_select_reg;
    logic [1:0]         edge_select_field_reg;
    logic [15:0]        carrier_period_setting_reg;
    logic [1:0]         inten_reg;

    // Core state
    logic [TIMER_W-1:0] ir_timer_count_reg;
    logic [TIMER_W-1:0] mark_space_capture_reg;
    logic               ir_event_flag_reg;
    logic               timer_overflow_flag_reg;
    gap_state_t         gap_state_reg;
    gap_state_t         gap_state_next;
    logic [1:0]         gap_cnt_reg;
    logic               ack_reg;
    logic [31:0]        rdata_reg;

    // Bus decode
    logic               bus_req;
    logic               wr_en;
    logic               wr_lo;
    logic               wr_hi;
    logic               ctrl_wr;
    logic               clear_wr;

    // Timer strobes
    logic               run;
    logic               step;
    logic               wrap;
    logic               space_hit;
    logic               capture_set;

    // Request, write and byte lane decode
    assign bus_req  = cyc_i & stb_i;
    assign wr_en    = bus_req & we_i & ack_reg;
    assign wr_lo    = wr_en & sel_i[0];
    assign wr_hi    = wr_en & sel_i[1];
    assign ctrl_wr  = wr_lo && (adr_i == `IRR_OFF_CTRL);
    assign clear_wr = wr_lo && (adr_i == `IRR_OFF_CLEAR);

    // One-cycle acknowledge, dropped the cycle after
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= bus_req & ~ack_reg;
        end
    end

    assign ack_o = ack_reg;

    // Control register writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            enable_reg              <= 1'b0;
            tx_mode_reg             <= 1'b0;
            reload_on_event_reg     <= 1'b0;
            burst_count_mode_reg    <= 1'b0;
            count_source_select_reg <= 1'b0;
            edge_select_field_reg   <= 2'h0;
        end else if (ctrl_wr) begin
            enable_reg              <= dat_i[`IRR_CTRL_ENABLE];
            tx_mode_reg             <= dat_i[`IRR_CTRL_TXMODE];
            reload_on_event_reg     <= dat_i[`IRR_CTRL_RELOAD];
            burst_count_mode_reg    <= dat_i[`IRR_CTRL_BURST];
            count_source_select_reg <= dat_i[`IRR_CTRL_SOURCE];
            edge_select_field_reg   <= dat_i[`IRR_CTRL_EDGE_HI:`IRR_CTRL_EDGE_LO];
        end
    end

    // Carrier period, byte lanes honoured
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            carrier_period_setting_reg <= `IRR_CARRIER_RST;
        end else if (adr_i == `IRR_OFF_CARRIER) begin
            if (wr_lo) begin
                carrier_period_setting_reg[7:0] <= dat_i[7:0];
            end
            if (wr_hi) begin
                carrier_period_setting_reg[15:8] <= dat_i[15:8];
            end
        end
    end

    // Interrupt enable register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            inten_reg <= 2'h0;
        end else if (wr_lo && adr_i == `IRR_OFF_INTEN) begin
            inten_reg <= dat_i[1:0];
        end
    end

    // Receive runs while enabled and not in transmit
    assign run = enable_reg & ~tx_mode_reg;
    assign rx_active_o = run;

    // Drive the qualifier side of the carrier
    assign ev.run            = run;
    assign ev.edge_sel       = edge_sel_t'(edge_select_field_reg);
    assign ev.carrier_period = carrier_period_setting_reg;

    ir_edge_qualify u_qualify (
        .clk_i   (clk_i),
        .rst_i   (rst_i),
        .ir_in_i (ir_in_i),
        .ev      (ev.qualifier)
    );

    // Count source: every clock or every carrier period
    assign step = run & (count_source_select_reg ? ev.carrier_tick : 1'b1);

    // Wrap from all ones without a qualified event
    assign wrap = step & (&ir_timer_count_reg) & ~ev.qual_edge;

    // IR timer: reload on event, otherwise free counting
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir_timer_count_reg <= '0;
        end else if (ev.qual_edge && reload_on_event_reg) begin
            ir_timer_count_reg <= '0;
        end else if (step) begin
            ir_timer_count_reg <= ir_timer_count_reg + TIMER_W'(1);
        end
    end

    // Capture in normal mode, edge counter in burst mode
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mark_space_capture_reg <= '0;
        end else if (ctrl_wr && dat_i[`IRR_CTRL_BURST] && !burst_count_mode_reg) begin
            // Fresh edge count on entering burst mode
            mark_space_capture_reg <= '0;
        end else if (ev.qual_edge) begin
            if (burst_count_mode_reg) begin
                mark_space_capture_reg <= mark_space_capture_reg + TIMER_W'(1);
            end else begin
                mark_space_capture_reg <= ir_timer_count_reg;
            end
        end
    end

    // Next state of the carrier gap tracker
    always_comb begin
        gap_state_next = gap_state_reg;
        unique case (gap_state_reg)
            GAP_IDLE: begin
                if (ev.qual_edge) begin
                    gap_state_next = GAP_COUNT;
                end
            end
            GAP_COUNT: begin
                if (ev.qual_edge) begin
                    gap_state_next = GAP_COUNT;
                end else if (space_hit) begin
                    gap_state_next = GAP_SPACE;
                end
            end
            GAP_SPACE: begin
                if (ev.qual_edge) begin
                    gap_state_next = GAP_COUNT;
                end
            end
            default: gap_state_next = GAP_IDLE;
        endcase
    end

    // Second carrier period ends with no edge
    assign space_hit = (gap_state_reg == GAP_COUNT) && ev.carrier_tick && !ev.qual_edge
                       && (gap_cnt_reg == `IRR_GAP_PERIODS - 2'h1);

    // Gap state, idle outside burst receive
    always_ff @(posedge clk_i) begin
        if (rst_i || !run || !burst_count_mode_reg) begin
            gap_state_reg <= GAP_IDLE;
        end else begin
            gap_state_reg <= gap_state_next;
        end
    end

    // Carrier periods since the last qualified edge
    always_ff @(posedge clk_i) begin
        if (rst_i || ev.qual_edge || gap_state_reg != GAP_COUNT) begin
            gap_cnt_reg <= 2'h0;
        end else if (ev.carrier_tick) begin
            gap_cnt_reg <= gap_cnt_reg + 2'h1;
        end
    end

    // Event flag meaning depends on the mode
    assign capture_set = burst_count_mode_reg
                       ? (burst_count_mode_reg & space_hit)
                       : ev.qual_edge;

    // Event flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ir_event_flag_reg <= 1'b0;
        end else if (capture_set) begin
            ir_event_flag_reg <= 1'b1;
        end else if (clear_wr && dat_i[`IRR_ST_EVENT]) begin
            ir_event_flag_reg <= 1'b0;
        end
    end

    // Overflow flag, set wins over clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            timer_overflow_flag_reg <= 1'b0;
        end else if (wrap) begin
            timer_overflow_flag_reg <= 1'b1;
        end else if (clear_wr && dat_i[`IRR_ST_OVF]) begin
            timer_overflow_flag_reg <= 1'b0;
        end
    end

    // Level interrupt from enabled sticky bits
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= (ir_event_flag_reg & inten_reg[`IRR_ST_EVENT])
                   | (timer_overflow_flag_reg & inten_reg[`IRR_ST_OVF]);
        end
    end

    // Read data latched on the request cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (bus_req && !ack_reg) begin
            rdata_reg <= 32'h0000_0000;
            unique case (adr_i)
                `IRR_OFF_CTRL: begin
                    rdata_reg[6:0] <= {edge_select_field_reg,
                                       count_source_select_reg,
                                       burst_count_mode_reg,
                                       reload_on_event_reg,
                                       tx_mode_reg,
                                       enable_reg};
                end
                `IRR_OFF_CARRIER: begin
                    rdata_reg[15:0] <= carrier_period_setting_reg;
                end
                `IRR_OFF_TIMER: begin
                    rdata_reg[TIMER_W-1:0] <= ir_timer_count_reg;
                end
                `IRR_OFF_CAPTURE: begin
                    rdata_reg[TIMER_W-1:0] <= mark_space_capture_reg;
                end
                `IRR_OFF_STATUS: begin
                    rdata_reg[1:0] <= {timer_overflow_flag_reg, ir_event_flag_reg};
                end
                `IRR_OFF_INTEN: begin
                    rdata_reg[1:0] <= inten_reg;
                end
                default: begin
                    // Clear register and unmapped offsets read zero
                    rdata_reg <= 32'h0000_0000;
                end
            endcase
        end
    end

    assign dat_o = rdata_reg;

endmodule // ir_receive_capture_burst_count

// ---- ir_rx_params.svh ----
// Constants of the IR receive capture block: offsets, fields, resets.
// Assumes a 32-bit classic Wishbone bus with byte addresses.
//
// Contract
// - Qualified event copies timer into capture
// - Reload timer to zero when reload bit set
// - Timer keeps counting after capture or reload
// - Wrap before event sets overflow, maybe interrupt
// - Receive runs until transmit chosen or disabled
// - Burst mode off: normal capture on events
// - Burst mode on: no capture, flag changes meaning
// - Burst mode: capture register counts qualified edges
// - Two carrier periods without edge set flag
// - Source bit picks clock or carrier cycles
// - Burst mode still honours reload and edge field
`ifndef IR_RX_PARAMS_SVH
`define IR_RX_PARAMS_SVH

// Register byte offsets
`define IRR_OFF_CTRL     8'h00
`define IRR_OFF_CARRIER  8'h04
`define IRR_OFF_TIMER    8'h08
`define IRR_OFF_CAPTURE  8'h0C
`define IRR_OFF_STATUS   8'h10
`define IRR_OFF_CLEAR    8'h14
`define IRR_OFF_INTEN    8'h18

// Control field positions
`define IRR_CTRL_ENABLE  0
`define IRR_CTRL_TXMODE  1
`define IRR_CTRL_RELOAD  2
`define IRR_CTRL_BURST   3
`define IRR_CTRL_SOURCE  4
`define IRR_CTRL_EDGE_LO 5
`define IRR_CTRL_EDGE_HI 6

// Status bit positions
`define IRR_ST_EVENT     0
`define IRR_ST_OVF       1

// Reset values and counts
`define IRR_CTRL_RST     7'h00
`define IRR_CARRIER_RST  16'h0000
`define IRR_GAP_PERIODS  2'h2

`endif

// ---- ir_rx_pkg.sv ----
// Types shared by the IR receive capture modules.
// Assumes ir_rx_params.svh supplies the numeric constants.
package ir_rx_pkg;

    // Edge qualification choices
    typedef enum logic [1:0] {
        EDGE_RISE  = 2'h0,
        EDGE_FALL  = 2'h1,
        EDGE_BOTH  = 2'h2,
        EDGE_BOTH2 = 2'h3
    } edge_sel_t;

    // Burst-mode carrier gap tracking
    typedef enum logic [2:0] {
        GAP_IDLE  = 3'b001,
        GAP_COUNT = 3'b010,
        GAP_SPACE = 3'b100
    } gap_state_t;

endpackage

// ---- ir_event_if.sv ----
// Carrier between the edge qualifier and the receive core.
// Assumes both ends share one clock.
`timescale 1ns/10ps
interface ir_event_if;
    import ir_rx_pkg::*;
    logic        run;          // Receive active
    edge_sel_t   edge_sel;     // Polarity choice
    logic [15:0] carrier_period;
    logic        qual_edge;    // One-cycle qualified edge
    logic        carrier_tick; // One-cycle carrier period end

    modport qualifier (input run, edge_sel, carrier_period,
                       output qual_edge, carrier_tick);
    modport core (output run, edge_sel, carrier_period,
                  input qual_edge, carrier_tick);
endinterface

// ---- ir_edge_qualify.sv ----
// Edge qualifier and carrier period divider.
// Assumes ir_in_i is synchronous to clk_i.
`timescale 1ns/10ps
module ir_edge_qualify
    import ir_rx_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic ir_in_i,
    ir_event_if.qualifier ev
);

    logic        in_prev_reg;
    logic [15:0] div_cnt_reg;
    logic        rise;
    logic        fall;

    // Previous input level
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            in_prev_reg <= 1'b0;
        end else begin
            in_prev_reg <= ir_in_i;
        end
    end

    assign rise = ir_in_i & ~in_prev_reg;
    assign fall = ~ir_in_i & in_prev_reg;

    // Polarity match against the chosen field
    always_comb begin
        unique case (ev.edge_sel)
            EDGE_RISE: ev.qual_edge = ev.run & rise;
            EDGE_FALL: ev.qual_edge = ev.run & fall;
            default:   ev.qual_edge = ev.run & (rise | fall);
        endcase
    end

    // Carrier period divider, period+1 clocks per tick
    always_ff @(posedge clk_i) begin
        if (rst_i || !ev.run || div_cnt_reg == ev.carrier_period) begin
            div_cnt_reg <= 16'h0000;
        end else begin
            div_cnt_reg <= div_cnt_reg + 16'h0001;
        end
    end

    assign ev.carrier_tick = ev.run && (div_cnt_reg == ev.carrier_period);

endmodule // ir_edge_qualify

// ---- ir_pin_model.sv ----
// Infrared receiver pin model: single toggles on request, or a carrier burst.
// Assumes requests arrive just after a rising edge of clk_i.
`timescale 1ns/10ps
module ir_pin_model (
    input  wire logic       clk_i,
    input  wire logic       flip_i,  // One toggle
    input  wire logic       go_i,    // Start a burst
    input  wire logic [7:0] half_i,  // Clocks between toggles, less one
    input  wire logic [7:0] edges_i, // Toggles in the burst
    output logic            ir_o,
    output logic            busy_o
);
    logic [7:0] wait_reg = 8'h00;
    logic [7:0] left_reg = 8'h00;

    // Demodulated pin is driven at all times and starts low
    initial ir_o = 1'b0;
    initial busy_o = 1'b0;

    // Toggle timing for single edges and bursts
    always @(posedge clk_i) begin
        if (go_i && !busy_o) begin
            busy_o   <= 1'b1;
            wait_reg <= half_i;
            left_reg <= edges_i;
        end else if (busy_o && wait_reg != 8'h00) begin
            wait_reg <= wait_reg - 8'h01;
        end else if (busy_o) begin
            ir_o     <= ~ir_o;
            wait_reg <= half_i;
            left_reg <= left_reg - 8'h01;
            busy_o   <= (left_reg != 8'h01);
        end else if (flip_i) begin
            ir_o <= ~ir_o;
        end
    end
endmodule // ir_pin_model

// ---- ir_rx_assertions.sv ----
// Checker of the IR receive block, seeing only its top ports.
// Assumes the register map of ir_rx_params.svh.
`timescale 1ns/10ps
`include "ir_rx_params.svh"
module ir_rx_checker #(
    parameter int TIMER_W = 16
) (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        cyc_i,
    input wire logic        stb_i,
    input wire logic        we_i,
    input wire logic [7:0]  adr_i,
    input wire logic [3:0]  sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic        ack_o,
    input wire logic        ir_in_i,
    input wire logic        irq_o,
    input wire logic        rx_active_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    // Accepted write decodes
    logic wr_any;
    logic wr_ctl;
    assign wr_any = ack_o && we_i && sel_i[0];
    assign wr_ctl = wr_any && adr_i == `IRR_OFF_CTRL;

    // Bus steps
    sequence s_req; cyc_i && stb_i && !ack_o; endsequence
    sequence s_ack; ack_o ##1 !ack_o; endsequence

    a_ack_one_cycle: assert property (s_req |=> s_ack) else $error("ack late or too long");
    a_ack_needs_req: assert property (ack_o |-> $past(cyc_i && stb_i)) else $error("ack without request");
    a_read_unmapped: assert property (ack_o && !we_i && adr_i >= 8'h1C |-> dat_o == 32'h0)
        else $error("unmapped read not zero");
    a_rx_follow_ctl: assert property (wr_ctl |=> rx_active_o ==
        ($past(dat_i[`IRR_CTRL_ENABLE]) && !$past(dat_i[`IRR_CTRL_TXMODE]))) else $error("receive state wrong");
    a_rx_hold_state: assert property (!wr_ctl |=> $stable(rx_active_o)) else $error("receive state moved");
    a_irq_cause: assert property ($rose(irq_o) |-> $past(rx_active_o, 2) || $past(ack_o && we_i, 2))
        else $error("irq rose without cause");
    a_irq_masked: assert property (wr_any && adr_i == `IRR_OFF_INTEN && dat_i[1:0] == 2'h0 |-> ##2 !irq_o)
        else $error("irq not masked");
    a_irq_cleared: assert property (wr_any && adr_i == `IRR_OFF_CLEAR && dat_i[1:0] == 2'h3 && !rx_active_o
        |-> ##2 !irq_o) else $error("irq not cleared");
endmodule // ir_rx_checker

bind ir_receive_capture_burst_count ir_rx_checker #(.TIMER_W(TIMER_W)) i_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i),
    .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .ir_in_i(ir_in_i),
    .irq_o(irq_o), .rx_active_o(rx_active_o));

// ---- tb_ir_receive_capture_burst_count.sv ----
// Self-checking bench of the IR receive timer block.
// Assumes the pin model and the checker are compiled before it.
`timescale 1ns/10ps
`include "ir_rx_params.svh"
module tb_ir_receive_capture_burst_count;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'h0;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o, ir_in_i, irq_o, rx_active_o, busy;
    logic        flip  = 1'b0;
    logic        go    = 1'b0;
    logic [7:0]  half  = 8'h00;
    logic [7:0]  edges = 8'h00;
    logic [3:0]  sel   = 4'hF;
    int          miscompares = 0;
    int          n_tests = 0;
    int          cycles = 0;

    always #10 clk_i = ~clk_i;

    ir_receive_capture_burst_count i_dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .ir_in_i(ir_in_i), .irq_o(irq_o), .rx_active_o(rx_active_o));
    ir_pin_model i_pin (.clk_i(clk_i), .flip_i(flip), .go_i(go), .half_i(half), .edges_i(edges),
        .ir_o(ir_in_i), .busy_o(busy));

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Cycle count and hang guard
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 90000) begin
            miscompares++;
            complete_run();
        end
    end

    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Classic cycle: hold until ack is sampled, then idle one cycle
    task automatic bus(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        sel_i <= sel;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask

    task automatic rdc(string nm, logic [7:0] a, logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, e, q);
    endtask

    task automatic flip_pin;
        flip <= 1'b1;
        @(posedge clk_i);
        flip <= 1'b0;
    endtask

    // Preset the pin so the next toggle has the chosen polarity
    task automatic qedge(logic [1:0] es, output int t);
        if ((es == 2'h0 && ir_in_i) || (es == 2'h1 && !ir_in_i)) begin
            flip_pin();
            repeat (3) @(posedge clk_i);
        end
        t = cycles;
        flip_pin();
    endtask

    function automatic logic [31:0] ctl(logic rl, logic bm, logic src, logic [1:0] es, logic tx = 1'b0);
        return {25'h0, es, src, bm, rl, tx, 1'b1};
    endfunction

    function automatic logic [31:0] cap_exp(logic rl, int dt, logic [31:0] c1);
        return rl ? 32'(dt - 1) : (c1 + 32'(dt)) & 32'h0000FFFF;
    endfunction

    initial begin
        int t1, t2, p, k;
        logic rl;
        logic [31:0] c1;
        void'($urandom(32'h57AA9472));
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int a = 0; a < 32; a += 4)
            if (a != 20) rdc("reset", 8'(a), 32'h0);
        // Write with lane 0 off is ignored
        sel = 4'h0;
        wr(`IRR_OFF_CTRL, 32'h1);
        sel = 4'hF;
        chk("rx_active", 32'h0, {31'h0, rx_active_o});
        wr(`IRR_OFF_INTEN, 32'h1);
        for (int es = 0; es < 4; es++) begin
            rl = 1'($urandom_range(1, 0));
            wr(`IRR_OFF_CTRL, ctl(rl, 1'b0, 1'b0, 2'(es)));
            wr(`IRR_OFF_CLEAR, 32'h3);
            qedge(2'(es), t1);
            repeat (4) @(posedge clk_i);
            bus(1'b0, `IRR_OFF_CAPTURE, 32'h0, c1);
            rdc("status", `IRR_OFF_STATUS, 32'h1);
            chk("irq", 32'h1, {31'h0, irq_o});
            repeat ($urandom_range(60, 20)) @(posedge clk_i);
            qedge(2'(es), t2);
            repeat (4) @(posedge clk_i);
            rdc("capture", `IRR_OFF_CAPTURE, cap_exp(rl, t2 - t1, c1));
        end
        // Carrier burst, then a gap of more than two periods
        p = $urandom_range(12, 6);
        k = $urandom_range(40, 20);
        wr(`IRR_OFF_CARRIER, 32'(p));
        rdc("carrier", `IRR_OFF_CARRIER, 32'(p));
        wr(`IRR_OFF_CTRL, ctl(1'b1, 1'b1, 1'b1, 2'h2));
        half  <= 8'($urandom_range(4, 2));
        edges <= 8'(k);
        go    <= 1'b1;
        @(posedge clk_i);
        go <= 1'b0;
        wr(`IRR_OFF_CLEAR, 32'h3);
        repeat (12) @(posedge clk_i);
        rdc("status", `IRR_OFF_STATUS, 32'h0);
        while (busy === 1'b1) @(posedge clk_i);
        repeat (3 * p + 8) @(posedge clk_i);
        rdc("bursts", `IRR_OFF_CAPTURE, 32'(k));
        rdc("status", `IRR_OFF_STATUS, 32'h1);
        // Carrier source: two periods apart, timer moves by two
        bus(1'b0, `IRR_OFF_TIMER, 32'h0, c1);
        repeat (2 * p - 1) @(posedge clk_i);
        rdc("timer", `IRR_OFF_TIMER, (c1 + 32'h2) & 32'h0000FFFF);
        // Transmit chosen: edges are not received
        wr(`IRR_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h2, 1'b1));
        wr(`IRR_OFF_CLEAR, 32'h3);
        flip_pin();
        repeat (4) @(posedge clk_i);
        rdc("status", `IRR_OFF_STATUS, 32'h0);
        // Overflow after a full wrap without an edge
        wr(`IRR_OFF_CTRL, ctl(1'b1, 1'b0, 1'b0, 2'h2));
        wr(`IRR_OFF_INTEN, 32'h2);
        qedge(2'h2, t1);
        wr(`IRR_OFF_CLEAR, 32'h3);
        while (cycles < t1 + 65500) @(posedge clk_i);
        rdc("overflow", `IRR_OFF_STATUS, 32'h0);
        repeat (60) @(posedge clk_i);
        rdc("overflow", `IRR_OFF_STATUS, 32'h2);
        chk("irq", 32'h1, {31'h0, irq_o});
        // The interrupt is registered: let one edge pass before looking
        wr(`IRR_OFF_INTEN, 32'h0);
        @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        wr(`IRR_OFF_INTEN, 32'h2);
        @(posedge clk_i);
        chk("irq", 32'h1, {31'h0, irq_o});
        wr(`IRR_OFF_CTRL, 32'h0);
        wr(`IRR_OFF_CLEAR, 32'h3);
        @(posedge clk_i);
        chk("irq", 32'h0, {31'h0, irq_o});
        // Disabled: an edge on the pin is not received
        flip_pin();
        repeat (4) @(posedge clk_i);
        rdc("status", `IRR_OFF_STATUS, 32'h0);
        complete_run();
    end
endmodule // tb_ir_receive_capture_burst_count
